// [card_status_pin_replace_regs.sv]
// attribute memory status and pin substitute register bank
`timescale 1ns/1ps
`default_nettype none

module card_status_pin_replace_regs
  import card_regs_pkg::*;
#(
  parameter int IDLE_CNT = IDLE_CYCLES
) (
  input  wire logic      i_core_clk,
  input  wire logic      i_rstn,
  input  wire attr_bus_t i_attr,
  input  wire logic      i_io_mode,
  input  wire logic      i_irq_req,
  input  wire logic      i_irq_disable_n,
  input  wire logic      i_core_busy,
  input  wire logic      i_cmd_strobe,
  input  wire logic      i_power_is_down,
  output logic [7:0]     o_data,
  output logic           o_data_oe,
  output logic           o_status_change_n,
  output logic           o_ready,
  output logic           o_power_down
);

  if (IDLE_CNT < 2) begin : g_idle_check
    $error("IDLE_CNT must be at least 2");
  end

  localparam int CW = $clog2(IDLE_CNT + 1);
  localparam logic [CW-1:0] IDLE_LAST = CW'(IDLE_CNT - 1);

  // decoding shared by read and write paths
  function automatic logic sel_at(input attr_bus_t b, input logic [10:0] off);
    sel_at = !b.reg_n && !b.ce1_n && (b.addr == off);
  endfunction

  attr_bus_t attr_q;
  logic      change_signal_enable;
  logic      byte_io_request;
  logic      power_save_request;
  logic      ready_toggle_latch;
  logic      wp_toggle_latch;
  logic      ready_live_state;
  logic      ready_live_q;
  logic      pwr_busy;
  logic      auto_sleep;
  logic [CW-1:0] idle_cnt;

  logic       write_stb;
  logic       wr_status;
  logic       wr_pin;
  logic       rd_status;
  logic       rd_pin;
  logic       changed;
  logic       wp_live_state;
  logic       irq_pending;
  logic       ready_toggle_mask;
  logic       wp_toggle_mask;
  logic       next_ready_live;
  logic [7:0] status_word;
  logic [7:0] pin_word;
  logic [7:0] next_data;

  // write is taken when the write strobe is released
  assign write_stb = !attr_q.we_n && i_attr.we_n;
  assign wr_status = write_stb && sel_at(attr_q, STATUS_OFFSET);
  assign wr_pin    = write_stb && sel_at(attr_q, PIN_OFFSET);
  assign rd_status = !i_attr.oe_n && i_attr.we_n
                     && sel_at(i_attr, STATUS_OFFSET);
  assign rd_pin    = !i_attr.oe_n && i_attr.we_n
                     && sel_at(i_attr, PIN_OFFSET);

  assign ready_toggle_mask = attr_q.data[PIN_RDY_BIT];
  assign wp_toggle_mask    = attr_q.data[PIN_WP_BIT];

  assign changed       = ready_toggle_latch | wp_toggle_latch;
  assign wp_live_state = 1'b0;
  assign irq_pending   = i_irq_req & ~i_irq_disable_n;
  assign next_ready_live = !(i_core_busy | pwr_busy);

  always_comb begin
    status_word = 8'h00;
    status_word[ST_CHANGED_BIT] = changed;
    status_word[ST_SIG_EN_BIT]  = change_signal_enable;
    status_word[ST_BYTE_IO_BIT] = byte_io_request;
    status_word[ST_PWR_BIT]     = power_save_request;
    status_word[ST_INT_BIT]     = irq_pending;
  end

  always_comb begin
    pin_word = PIN_FIXED_ONES;
    pin_word[PIN_RDY_TGL_BIT] = ready_toggle_latch;
    pin_word[PIN_WP_TGL_BIT]  = wp_toggle_latch;
    pin_word[PIN_RDY_BIT]     = ready_live_state;
    pin_word[PIN_WP_BIT]      = wp_live_state;
  end

  always_comb begin
    next_data = 8'h00;
    if (rd_status) begin
      next_data = status_word;
    end else if (rd_pin) begin
      next_data = pin_word;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      attr_q <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  addr: 11'h000, data: 8'h00};
    end else begin
      attr_q <= i_attr;
    end
  end

  // read data on the low byte only
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data    <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data    <= next_data;
      o_data_oe <= rd_status | rd_pin;
    end
  end

  // host controlled status bits; unused bits are simply not stored
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      change_signal_enable <= RST_SIG_EN;
      byte_io_request      <= RST_BYTE_IO;
      power_save_request   <= RST_PWR;
    end else if (wr_status) begin
      change_signal_enable <= attr_q.data[ST_SIG_EN_BIT];
      byte_io_request      <= attr_q.data[ST_BYTE_IO_BIT];
      power_save_request   <= attr_q.data[ST_PWR_BIT];
    end
  end

  // toggle latches: a hardware set wins over a host clear
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_toggle_latch <= RST_TGL;
    end else if (ready_live_state != ready_live_q) begin
      ready_toggle_latch <= 1'b1;
    end else if (wr_pin && ready_toggle_mask) begin
      ready_toggle_latch <= attr_q.data[PIN_RDY_TGL_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_toggle_latch <= RST_TGL;
    end else if (wp_live_state) begin
      wp_toggle_latch <= 1'b1;
    end else if (wr_pin && wp_toggle_mask) begin
      wp_toggle_latch <= attr_q.data[PIN_WP_TGL_BIT];
    end
  end

  // busy from a power request change until the domain reports it reached
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_busy <= 1'b0;
    end else if (wr_status
                 && attr_q.data[ST_PWR_BIT] != power_save_request) begin
      pwr_busy <= 1'b1;
    end else if (i_power_is_down == power_save_request) begin
      pwr_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_live_state <= RST_READY;
      ready_live_q     <= RST_READY;
      o_ready          <= RST_READY;
    end else begin
      ready_live_state <= next_ready_live;
      ready_live_q     <= ready_live_state;
      o_ready          <= next_ready_live;
    end
  end

  // idle timer for automatic sleep; a command wakes at once
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_cnt   <= '0;
      auto_sleep <= 1'b0;
    end else if (i_cmd_strobe || i_core_busy) begin
      idle_cnt   <= '0;
      auto_sleep <= 1'b0;
    end else if (idle_cnt == IDLE_LAST) begin
      auto_sleep <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_power_down <= 1'b0;
    end else begin
      o_power_down <= power_save_request | auto_sleep;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status_change_n <= 1'b1;
    end else begin
      o_status_change_n <= !(i_io_mode && changed
                             && change_signal_enable);
    end
  end

  a_change_out_drive: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    ##1 o_status_change_n == !$past(i_io_mode && changed
                                    && change_signal_enable))
    else $error("status change output wrong");

  a_change_out_quiet: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_io_mode && !change_signal_enable) |=> o_status_change_n)
    else $error("status change low while disabled");

  a_changed_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_status |=> o_data[ST_CHANGED_BIT] == $past(changed) && o_data_oe)
    else $error("changed flag not the latch or");

  a_irq_masked: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_status && i_irq_disable_n) |=> !o_data[ST_INT_BIT])
    else $error("pending bit set while disabled");

  a_irq_mirror: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (rd_status && !i_irq_disable_n)
    |=> o_data[ST_INT_BIT] == $past(i_irq_req))
    else $error("pending bit does not follow request");

  a_status_zeros: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_status |=> o_data_oe && o_data[4:3] == 2'b00 && !o_data[0])
    else $error("status word unused bits not zero");

  a_pin_fixed: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    rd_pin |=> o_data[7:6] == 2'b00 && o_data[3:2] == 2'b11
               && !o_data[PIN_WP_BIT])
    else $error("pin word fixed bits wrong");

  a_ready_latch_set: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (ready_live_state != ready_live_q) |=> ready_toggle_latch)
    else $error("ready toggle latch missed change");

  a_mask_keep: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_pin && !ready_toggle_mask && ready_live_state == ready_live_q)
    |=> $stable(ready_toggle_latch))
    else $error("masked write altered ready latch");

  a_ready_mask_load: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_pin && ready_toggle_mask && ready_live_state == ready_live_q)
    |=> ready_toggle_latch == $past(attr_q.data[PIN_RDY_TGL_BIT]))
    else $error("ready latch did not take written value");

  a_mask_load: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_pin && wp_toggle_mask)
    |=> wp_toggle_latch == $past(attr_q.data[PIN_WP_TGL_BIT]))
    else $error("wp latch did not take written value");

  a_wp_host_only: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(wr_pin && wp_toggle_mask) |=> $stable(wp_toggle_latch))
    else $error("wp latch moved without host write");

  a_busy_on_change: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_status && attr_q.data[ST_PWR_BIT] != power_save_request)
    |=> ##1 !ready_live_state && !o_ready)
    else $error("power change did not show busy");

  a_busy_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    pwr_busy |=> !o_ready && !ready_live_state)
    else $error("ready shown before power state reached");

  a_power_follow: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (wr_status && attr_q.data[ST_PWR_BIT]) |=> ##1 o_power_down)
    else $error("power down not requested");

  a_wake_on_cmd: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_cmd_strobe && !power_save_request && !wr_status)
    |=> ##1 !o_power_down)
    else $error("command did not wake the card");

  a_read_quiet: assert property (
    @(posedge i_core_clk) disable iff (!i_rstn)
    !(rd_status || rd_pin) |=> !o_data_oe && o_data == 8'h00)
    else $error("data driven without a register read");

endmodule // card_status_pin_replace_regs

`default_nettype wire

// [card_regs_pkg.sv]
// constants and carrier types for the card status and pin substitute registers
`default_nettype none
package card_regs_pkg;

  localparam logic [10:0] STATUS_OFFSET = 11'h202;
  localparam logic [10:0] PIN_OFFSET    = 11'h204;

  // status word fields
  localparam int ST_CHANGED_BIT = 7;
  localparam int ST_SIG_EN_BIT  = 6;
  localparam int ST_BYTE_IO_BIT = 5;
  localparam int ST_PWR_BIT     = 2;
  localparam int ST_INT_BIT     = 1;

  // pin word fields
  localparam int PIN_RDY_TGL_BIT = 5;
  localparam int PIN_WP_TGL_BIT  = 4;
  localparam int PIN_RDY_BIT     = 1;
  localparam int PIN_WP_BIT      = 0;
  localparam logic [7:0] PIN_FIXED_ONES = 8'h0c;

  // values after reset
  localparam logic RST_SIG_EN  = 1'b0;
  localparam logic RST_BYTE_IO = 1'b0;
  localparam logic RST_PWR     = 1'b0;
  localparam logic RST_TGL     = 1'b0;
  localparam logic RST_READY   = 1'b1;

  // idle time before automatic power down
  localparam int IDLE_TIME_US   = 5000;
  localparam int CLK_MHZ        = 40;
  localparam int IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic        reg_n;
    logic        ce1_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
    logic [7:0]  data;
  } attr_bus_t;

endpackage

`default_nettype wire

// [attr_host.sv]
// host socket controller model driving the attribute bus
`timescale 1ns/1ps
`default_nettype none

module attr_host
  import card_regs_pkg::*;
(
  input  wire logic      i_core_clk,
  output var  attr_bus_t o_bus
);
  // released bus: strobes high, data lines keep moving
  task automatic idle();
    o_bus.reg_n = 1'b1;
    o_bus.ce1_n = 1'b1;
    o_bus.oe_n  = 1'b1;
    o_bus.we_n  = 1'b1;
    o_bus.data  = ~o_bus.data;
  endtask

  initial begin
    o_bus = '0;
    idle();
  end

  // byte write: we_n low one cycle, then high, then release
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_bus = '{1'b0, 1'b0, 1'b1, 1'b0, a, d};
    @(negedge i_core_clk);
    o_bus.we_n = 1'b1;
    @(negedge i_core_clk);
    idle();
  endtask

  // byte read held for one sampling edge
  task automatic rd(input logic [10:0] a);
    @(negedge i_core_clk);
    o_bus = '{1'b0, 1'b0, 1'b0, 1'b1, a, o_bus.data};
    @(negedge i_core_clk);
    idle();
  endtask
endmodule // attr_host

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the status and pin substitute registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import card_regs_pkg::*;
  logic       i_core_clk, i_rstn, io_mode, irq_req, irq_dis;
  logic       core_busy, cmd, pwr_down, rd_oe, stat_n, ready, pdown;
  logic [7:0] rdata, d;
  attr_bus_t  bus;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hfa8f;

  attr_host host (.i_core_clk(i_core_clk), .o_bus(bus));

  card_status_pin_replace_regs #(.IDLE_CNT(8)) uut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_attr(bus),
    .i_io_mode(io_mode), .i_irq_req(irq_req),
    .i_irq_disable_n(irq_dis), .i_core_busy(core_busy),
    .i_cmd_strobe(cmd), .i_power_is_down(pwr_down),
    .o_data(rdata), .o_data_oe(rd_oe), .o_status_change_n(stat_n),
    .o_ready(ready), .o_power_down(pdown));

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // read data watcher: any drive must match the oldest note
  always @(negedge i_core_clk) begin
    if (rd_oe !== 1'b0) begin
      if (exp_q.size() == 0) check({7'h0, rd_oe}, 8'h00);
      else check(rdata, exp_q.pop_front());
    end
  end

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {io_mode, irq_req, irq_dis, core_busy, cmd, pwr_down} = '0;
    i_rstn = 1'b0;
    cyc(5);
    i_rstn = 1'b1;
    cyc(1);
    rd(STATUS_OFFSET, 8'h00);
    rd(PIN_OFFSET, 8'h0e);
    seed = lfsr(seed);
    d = seed[15:8] & 8'h60;
    host.wr(STATUS_OFFSET, d);
    rd(STATUS_OFFSET, d);
    host.wr(11'h206, seed[7:0]);
    host.rd(11'h203);
    rd(STATUS_OFFSET, d);
    io_mode = 1'b1;
    host.wr(STATUS_OFFSET, 8'h40);
    host.wr(PIN_OFFSET, 8'h33);
    rd(PIN_OFFSET, 8'h3e);
    rd(STATUS_OFFSET, 8'hc0);
    check({7'h0, stat_n}, 8'h00);
    host.wr(PIN_OFFSET, 8'h10);
    rd(PIN_OFFSET, 8'h3e);
    host.wr(PIN_OFFSET, 8'h02);
    rd(PIN_OFFSET, 8'h1e);
    host.wr(STATUS_OFFSET, 8'h00);
    cyc(2);
    check({7'h0, stat_n}, 8'h01);
    host.wr(PIN_OFFSET, 8'h01);
    rd(STATUS_OFFSET, 8'h00);
    irq_req = 1'b1;
    rd(STATUS_OFFSET, 8'h02);
    irq_dis = 1'b1;
    rd(STATUS_OFFSET, 8'h00);
    {irq_req, irq_dis} = 2'b00;
    host.wr(STATUS_OFFSET, 8'h04);
    cyc(2);
    check({6'h0, pdown, ready}, 8'h02);
    cyc(4);
    check({7'h0, ready}, 8'h00);
    pwr_down = 1'b1;
    cyc(3);
    check({7'h0, ready}, 8'h01);
    rd(PIN_OFFSET, 8'h2e);
    host.wr(STATUS_OFFSET, 8'h00);
    cyc(3);
    pwr_down = 1'b0;
    cyc(3);
    check({7'h0, ready}, 8'h01);
    host.wr(PIN_OFFSET, 8'h02);
    core_busy = 1'b1;
    cyc(3);
    check({7'h0, ready}, 8'h00);
    rd(PIN_OFFSET, 8'h2c);
    core_busy = 1'b0;
    cyc(12);
    check({7'h0, pdown}, 8'h01);
    cmd = 1'b1;
    cyc(1);
    cmd = 1'b0;
    cyc(1);
    check({7'h0, pdown}, 8'h00);
    host.wr(STATUS_OFFSET, 8'h64);
    host.wr(PIN_OFFSET, 8'h33);
    cyc(2);
    check({7'h0, stat_n}, 8'h00);
    i_rstn = 1'b0;
    cyc(2);
    i_rstn = 1'b1;
    cyc(1);
    check({7'h0, stat_n}, 8'h01);
    rd(STATUS_OFFSET, 8'h00);
    rd(PIN_OFFSET, 8'h0e);
    cyc(3);
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
